// ---- ssp_pkg.sv ----
// Shared constants, types and check-code function for the sensor programming port
package ssp_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int SCLK_MAX_HZ = 10_000_000;
  localparam int SCLK_HALF_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  // Device register byte addresses
  localparam logic [5:0] A_XWR_HI = 6'h04;
  localparam logic [5:0] A_XWR_LO = 6'h06;
  localparam logic [5:0] A_CFG = 6'h1A;
  localparam logic [5:0] A_OVR = 6'h1C;
  localparam logic [5:0] A_CTRL = 6'h1E;
  localparam logic [5:0] A_ANGLE = 6'h20;
  localparam logic [5:0] A_STAT = 6'h22;
  localparam logic [5:0] A_ERR = 6'h24;
  localparam logic [5:0] A_TDH = 6'h28;
  localparam logic [5:0] A_TDL = 6'h2A;
  localparam logic [5:0] A_ODD = 6'h01;
  // Commands
  localparam logic [7:0] CMD_TURNS_RESET = 8'h01;
  localparam logic [7:0] CMD_TURNS_LOAD = 8'h03;
  localparam logic [7:0] TRIGGER_KEY = 8'h46;
  // Settings byte fields, then warning and status bit positions
  localparam int CFG_CHK = 0;
  localparam int CFG_LEN17 = 1;
  localparam int CFG_PWM = 2;
  localparam int CFG_MDIS = 3;
  localparam int CFG_SENT = 4;
  localparam int CFG_TINIT_HI = 6;
  localparam int CFG_LOCK = 7;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int ERR_IFACE = 0;
  localparam int ERR_CRC = 1;
  localparam int STAT_STABLE = 0;
  localparam int STAT_MCH = 1;
  // Frame layout
  localparam int FRM_RW = 14;
  localparam int FRM_ADDR_LSB = 8;
  localparam logic [4:0] LEN16 = 5'h10;
  localparam logic [4:0] LEN17 = 5'h11;
  localparam logic [4:0] LEN20 = 5'h14;
  localparam logic [3:0] CRC_PRESET = 4'hF;
  // Host register offsets and fields
  localparam logic [3:0] H_FRAME = 4'h0;
  localparam logic [3:0] H_STAT = 4'h4;
  localparam logic [3:0] H_RX = 4'h8;
  localparam int HF_LEN_LSB = 16;

  typedef enum logic [3:0] {
    OWN_SPI = 4'b0001,
    OWN_MCH = 4'b0010,
    OWN_PWM = 4'b0100,
    OWN_SENT = 4'b1000
  } ssp_owner_t;

  function automatic logic [3:0] crc4(input logic [15:0] d);
    logic [3:0] c;
    logic inv;
    c = CRC_PRESET;
    inv = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      inv = d[i] ^ c[3];
      c = {c[2], c[1], c[0] ^ inv, inv};
    end
    return c;
  endfunction
endpackage

// ---- ssp_if.sv ----
// Four-wire serial link between host controller and sensor port
interface ssp_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  modport dev (input sclk, input csN, input mosi, output miso);
  modport host (output sclk, output csN, output mosi, input miso);
endinterface

// ---- ssp_device.sv ----
// Sensor end of the serial programming port with turns accumulator and pin arbitration
//
// Added by the designer: strobed register access.
module ssp_device (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  ssp_if.dev link,
  input wire logic [11:0] angleIn,
  input wire logic systemStable,
  input wire logic mchWrEn,
  input wire logic [5:0] mchAddr,
  input wire logic [7:0] mchData,
  input wire logic mchAuxPulse,
  input wire logic mchExit,
  output ssp_pkg::ssp_owner_t pinOwner,
  output logic mchSession,
  output logic [20:0] turnsDelta
);
  logic [2:0] sclkSy_ff;
  logic [2:0] csSy_ff;
  logic [1:0] mosiSy_ff;
  logic [19:0] rxSh_ff;
  logic [4:0] bitCnt_ff;
  logic [19:0] txSh_ff;
  logic [5:0] sel_ff;
  logic [15:0] xwrHi_ff;
  logic [15:0] xwrLo_ff;
  logic [7:0] cfg_ff;
  logic ovr_ff;
  logic [7:0] cmd_ff;
  logic sess_ff;
  ssp_pkg::ssp_owner_t owner_ff;
  logic [11:0] prevAngle_ff;
  logic [20:0] acc_ff;
  logic started_ff;
  logic ierr_ff;
  logic crcErr_ff;

  logic sclkRise, sclkFall, csFall, csRise, csLow, mosiS;
  logic opt17, chkEn, mchDis, lenOk, crcBad, accept, spiWr, spiRd;
  logic [15:0] frame;
  logic mchOk, wrEn, fire;
  logic [5:0] wrAddr;
  logic [7:0] wrData;
  logic [15:0] rdWord, rdData;
  logic [11:0] angleStep, snapDiff;
  logic [20:0] loaded;
  logic errClr;

  // Link pins are asynchronous; edge and level decode use only stages 1 and 2
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclkSy_ff <= 3'h0;
      csSy_ff <= 3'h7;
      mosiSy_ff <= 2'h0;
    end else if (ce) begin
      sclkSy_ff <= {sclkSy_ff[1:0], link.sclk};
      csSy_ff <= {csSy_ff[1:0], link.csN};
      mosiSy_ff <= {mosiSy_ff[0], link.mosi};
    end
  end

  assign sclkRise = sclkSy_ff[1] & ~sclkSy_ff[2];
  assign sclkFall = ~sclkSy_ff[1] & sclkSy_ff[2];
  assign csFall = ~csSy_ff[1] & csSy_ff[2];
  assign csRise = csSy_ff[1] & ~csSy_ff[2];
  assign csLow = ~csSy_ff[1];
  assign mosiS = mosiSy_ff[1];

  assign opt17 = cfg_ff[ssp_pkg::CFG_LEN17];
  assign chkEn = cfg_ff[ssp_pkg::CFG_CHK];
  assign mchDis = cfg_ff[ssp_pkg::CFG_MDIS];

  // Receive shifter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxSh_ff <= 20'h00000;
      bitCnt_ff <= 5'h00;
    end else if (ce) begin
      if (!csLow) begin
        bitCnt_ff <= 5'h00;
      end else if (sclkRise) begin
        rxSh_ff <= {rxSh_ff[18:0], mosiS};
        if (bitCnt_ff != 5'h1F) begin
          bitCnt_ff <= bitCnt_ff + 5'h01;
        end
      end
    end
  end

  // Frame decode at chip-select release
  always_comb begin
    lenOk = opt17 ? (bitCnt_ff == ssp_pkg::LEN17) :
            (bitCnt_ff == ssp_pkg::LEN16 || bitCnt_ff == ssp_pkg::LEN20);
    if (bitCnt_ff == ssp_pkg::LEN20) begin
      frame = rxSh_ff[19:4];
    end else if (bitCnt_ff == ssp_pkg::LEN17) begin
      frame = rxSh_ff[16:1];
    end else begin
      frame = rxSh_ff[15:0];
    end
    crcBad = chkEn && bitCnt_ff == ssp_pkg::LEN20 && ssp_pkg::crc4(frame) != rxSh_ff[3:0];
  end

  // Frames of illegal length are flagged and also dropped
  assign accept = csRise && lenOk && !crcBad;
  assign spiWr = accept && frame[ssp_pkg::FRM_RW];
  assign spiRd = accept && !frame[ssp_pkg::FRM_RW];

  // SPI wins a same-cycle collision; the Manchester write is then lost
  assign mchOk = mchWrEn && !mchDis && !ovr_ff &&
                 (sess_ff || !(cfg_ff[ssp_pkg::CFG_PWM] || cfg_ff[ssp_pkg::CFG_SENT]));
  assign wrEn = spiWr || mchOk;
  assign wrAddr = spiWr ? frame[ssp_pkg::FRM_ADDR_LSB +: 6] : mchAddr;
  assign wrData = spiWr ? frame[7:0] : mchData;
  assign fire = wrEn && wrAddr == (ssp_pkg::A_CTRL | ssp_pkg::A_ODD) &&
                wrData == ssp_pkg::TRIGGER_KEY;

  // Register writes; even address is the high byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xwrHi_ff <= 16'h0000;
      xwrLo_ff <= 16'h0000;
      cfg_ff <= ssp_pkg::CFG_RST;
      ovr_ff <= 1'b0;
      cmd_ff <= 8'h00;
    end else if (ce && wrEn) begin
      unique case (wrAddr)
        ssp_pkg::A_XWR_HI: xwrHi_ff[15:8] <= wrData;
        ssp_pkg::A_XWR_HI | ssp_pkg::A_ODD: xwrHi_ff[7:0] <= wrData;
        ssp_pkg::A_XWR_LO: xwrLo_ff[15:8] <= wrData;
        ssp_pkg::A_XWR_LO | ssp_pkg::A_ODD: xwrLo_ff[7:0] <= wrData;
        ssp_pkg::A_CFG | ssp_pkg::A_ODD: begin
          if (!cfg_ff[ssp_pkg::CFG_LOCK]) begin
            cfg_ff <= wrData;
          end
        end
        ssp_pkg::A_OVR | ssp_pkg::A_ODD: ovr_ff <= wrData[0];
        ssp_pkg::A_CTRL: cmd_ff <= wrData;
        // Accumulator and read-only addresses take no write
        default: ;
      endcase
    end
  end

  // Manchester session
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sess_ff <= 1'b0;
    end else if (ce) begin
      if (mchDis || ovr_ff || mchExit) begin
        sess_ff <= 1'b0;
      end else if (mchAuxPulse) begin
        sess_ff <= 1'b1;
      end
    end
  end

  // Shared pin owner
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      owner_ff <= ssp_pkg::OWN_MCH;
    end else if (ce) begin
      if (ovr_ff) begin
        owner_ff <= ssp_pkg::OWN_SPI;
      end else if (sess_ff) begin
        owner_ff <= ssp_pkg::OWN_MCH;
      end else if (cfg_ff[ssp_pkg::CFG_PWM]) begin
        owner_ff <= ssp_pkg::OWN_PWM;
      end else if (cfg_ff[ssp_pkg::CFG_SENT]) begin
        owner_ff <= ssp_pkg::OWN_SENT;
      end else if (mchDis) begin
        owner_ff <= ssp_pkg::OWN_SPI;
      end else begin
        owner_ff <= ssp_pkg::OWN_MCH;
      end
    end
  end

  // Turns accumulator
  assign angleStep = angleIn - prevAngle_ff;
  assign loaded = {xwrHi_ff[4:0], xwrLo_ff};
  assign snapDiff = angleIn - loaded[11:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevAngle_ff <= 12'h000;
      acc_ff <= 21'h000000;
      started_ff <= 1'b0;
    end else if (ce) begin
      prevAngle_ff <= angleIn;
      started_ff <= 1'b1;
      if (!started_ff || (fire && cmd_ff == ssp_pkg::CMD_TURNS_RESET)) begin
        acc_ff <= cfg_ff[ssp_pkg::CFG_TINIT_HI] ? {9'h000, angleIn} : 21'h000000;
      end else if (fire && cmd_ff == ssp_pkg::CMD_TURNS_LOAD) begin
        if (cfg_ff[ssp_pkg::CFG_TINIT_HI]) begin
          // Signed step of at most half a turn toward the sensed angle
          acc_ff <= loaded + {{9{snapDiff[11]}}, snapDiff};
        end else begin
          acc_ff <= loaded;
        end
      end else begin
        acc_ff <= acc_ff + {{9{angleStep[11]}}, angleStep};
      end
    end
  end

  // Warning flags, cleared when their register is shifted out
  assign errClr = csFall && sel_ff[5:1] == ssp_pkg::A_ERR[5:1];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ierr_ff <= 1'b0;
      crcErr_ff <= 1'b0;
    end else if (ce) begin
      ierr_ff <= (csRise && !lenOk) || (ierr_ff && !errClr);
      crcErr_ff <= (csRise && lenOk && crcBad) || (crcErr_ff && !errClr);
    end
  end

  // Read selection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_ff <= ssp_pkg::A_ANGLE;
    end else if (ce) begin
      if (spiRd) begin
        sel_ff <= frame[ssp_pkg::FRM_ADDR_LSB +: 6];
      end else if (spiWr) begin
        sel_ff <= ssp_pkg::A_ANGLE;
      end
    end
  end

  always_comb begin
    unique case ({sel_ff[5:1], 1'b0})
      ssp_pkg::A_XWR_HI: rdWord = xwrHi_ff;
      ssp_pkg::A_XWR_LO: rdWord = xwrLo_ff;
      ssp_pkg::A_CFG: rdWord = {8'h00, cfg_ff};
      ssp_pkg::A_OVR: rdWord = {15'h0000, ovr_ff};
      ssp_pkg::A_CTRL: rdWord = {cmd_ff, 8'h00};
      ssp_pkg::A_ANGLE: rdWord = {4'h0, angleIn};
      ssp_pkg::A_STAT: rdWord = {14'h0000, sess_ff, systemStable};
      ssp_pkg::A_ERR: rdWord = {14'h0000, crcErr_ff, ierr_ff};
      ssp_pkg::A_TDH: rdWord = {11'h000, acc_ff[20:16]};
      ssp_pkg::A_TDL: rdWord = acc_ff[15:0];
      default: rdWord = 16'h0000;
    endcase
    rdData = sel_ff[0] ? {8'h00, rdWord[7:0]} : rdWord;
  end

  // Transmit shifter: loaded at frame start, advanced on falling edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txSh_ff <= 20'h00000;
    end else if (ce) begin
      if (csFall) begin
        txSh_ff <= {rdData, ssp_pkg::crc4(rdData)};
      end else if (csLow && sclkFall) begin
        txSh_ff <= {txSh_ff[18:0], 1'b0};
      end else if (csRise) begin
        txSh_ff <= 20'h00000;
      end
    end
  end

  assign link.miso = txSh_ff[19];
  assign pinOwner = owner_ff;
  assign mchSession = sess_ff;
  assign turnsDelta = acc_ff;
endmodule

// ---- ssp_host.sv ----
// Host controller end: register-driven frame engine that clocks the link
module ssp_host #(
  parameter int HALF_CYC = ssp_pkg::SCLK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  ssp_if.host link,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata
);
  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_LOW = 5'b00010,
    HS_HIGH = 5'b00100,
    HS_TAIL = 5'b01000,
    HS_GAP = 5'b10000
  } ssp_hstate_t;

  ssp_hstate_t state_ff;
  logic [7:0] div_ff;
  logic [4:0] bitCnt_ff;
  logic [4:0] len_ff;
  logic [19:0] txSh_ff;
  logic [19:0] rxSh_ff;
  logic sclk_ff;
  logic csN_ff;
  logic mosi_ff;
  logic [1:0] misoSy_ff;
  logic [15:0] rxWord_ff;
  logic [3:0] rxCrc_ff;
  logic rxOk_ff;
  logic [31:0] rdata_ff;
  logic tick, start, mode17;
  logic [15:0] rxData;
  logic [1:0] lenSel;

  assign tick = div_ff == 8'(HALF_CYC - 1);
  assign start = regWr && regAddr == ssp_pkg::H_FRAME && state_ff == HS_IDLE;
  assign mode17 = len_ff == ssp_pkg::LEN17;
  assign lenSel = regWdata[ssp_pkg::HF_LEN_LSB +: 2];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      misoSy_ff <= 2'h0;
    end else if (ce) begin
      misoSy_ff <= {misoSy_ff[0], link.miso};
    end
  end

  // Frame sequencer; a write while busy is ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= HS_IDLE;
      div_ff <= 8'h00;
      bitCnt_ff <= 5'h00;
      len_ff <= ssp_pkg::LEN16;
      txSh_ff <= 20'h00000;
      rxSh_ff <= 20'h00000;
      sclk_ff <= 1'b0;
      csN_ff <= 1'b1;
      mosi_ff <= 1'b0;
    end else if (ce) begin
      div_ff <= (tick || state_ff == HS_IDLE) ? 8'h00 : div_ff + 8'h01;
      unique case (state_ff)
        HS_IDLE: begin
          if (start) begin
            unique case (lenSel)
              2'h0: len_ff <= ssp_pkg::LEN16;
              2'h1: len_ff <= ssp_pkg::LEN17;
              default: len_ff <= ssp_pkg::LEN20;
            endcase
            txSh_ff <= {regWdata[15:0], ssp_pkg::crc4(regWdata[15:0])};
            mosi_ff <= regWdata[15];
            csN_ff <= 1'b0;
            bitCnt_ff <= 5'h00;
            state_ff <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tick) begin
            sclk_ff <= 1'b1;
            bitCnt_ff <= bitCnt_ff + 5'h01;
            if (!mode17) begin
              rxSh_ff <= {rxSh_ff[18:0], misoSy_ff[1]};
            end
            state_ff <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (tick) begin
            sclk_ff <= 1'b0;
            if (mode17) begin
              // Falling-edge sampling needs the extra seventeenth clock
              rxSh_ff <= {rxSh_ff[18:0], misoSy_ff[1]};
            end
            if (bitCnt_ff == len_ff) begin
              state_ff <= HS_TAIL;
            end else begin
              mosi_ff <= txSh_ff[18];
              txSh_ff <= {txSh_ff[18:0], 1'b0};
              state_ff <= HS_LOW;
            end
          end
        end
        HS_TAIL: begin
          if (tick) begin
            csN_ff <= 1'b1;
            state_ff <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (tick) begin
            state_ff <= HS_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    if (len_ff == ssp_pkg::LEN20) begin
      rxData = rxSh_ff[19:4];
    end else if (mode17) begin
      rxData = rxSh_ff[16:1];
    end else begin
      rxData = rxSh_ff[15:0];
    end
  end

  // Result of the last frame; a read frame's answer arrives in the next one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxWord_ff <= 16'h0000;
      rxCrc_ff <= 4'h0;
      rxOk_ff <= 1'b0;
    end else if (ce && state_ff == HS_TAIL && tick) begin
      rxWord_ff <= rxData;
      rxCrc_ff <= rxSh_ff[3:0];
      rxOk_ff <= ssp_pkg::crc4(rxData) == rxSh_ff[3:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 32'h00000000;
    end else if (ce) begin
      if (regRd && regAddr == ssp_pkg::H_STAT) begin
        rdata_ff <= {31'h00000000, state_ff != HS_IDLE};
      end else if (regRd && regAddr == ssp_pkg::H_RX) begin
        rdata_ff <= {11'h000, rxOk_ff, rxCrc_ff, rxWord_ff};
      end else begin
        rdata_ff <= 32'h00000000;
      end
    end
  end

  assign link.sclk = sclk_ff;
  assign link.csN = csN_ff;
  assign link.mosi = mosi_ff;
  assign regRdata = rdata_ff;
endmodule

// ---- ssp_link_asserts.sv ----
// Concurrent checks on the serial link between host and sensor ends
module ssp_link_asserts #(
  parameter int HALF_CYC = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso
);
  logic sclkDly_ff;
  logic [7:0] hiCnt_ff;
  logic [5:0] riseCnt_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sclkDly_ff <= 1'b0;
    else sclkDly_ff <= sclk;
  end

  // Length of the current high phase, read back when the clock falls
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) hiCnt_ff <= 8'h00;
    else hiCnt_ff <= sclk ? hiCnt_ff + 8'h01 : 8'h00;
  end

  // Cleared while deselected so each frame is counted from its first edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) riseCnt_ff <= 6'h00;
    else if (csN) riseCnt_ff <= 6'h00;
    else riseCnt_ff <= riseCnt_ff + {5'h00, sclk & !sclkDly_ff};
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_gap;
    csN [*3];
  endsequence
  sequence s_lead;
    !sclk [*2];
  endsequence

  property p_sclk_idle; csN |-> !sclk; endproperty
  property p_mosi_hold; sclk |-> $stable(mosi); endproperty
  property p_miso_on_low; !csN && $changed(miso) |-> !sclk; endproperty
  property p_sclk_high; $fell(sclk) |-> hiCnt_ff == HALF_CYC[7:0]; endproperty
  property p_frame_len; $rose(csN) |-> riseCnt_ff inside {6'h10, 6'h11, 6'h14}; endproperty
  property p_cs_gap; $rose(csN) |-> s_gap; endproperty
  property p_lead; $fell(csN) |-> s_lead; endproperty
  property p_miso_idle; csN [*5] |-> !miso; endproperty

  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk high while deselected");
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sclk high");
  a_miso_on_low: assert property (p_miso_on_low) else $error("miso moved while sclk high");
  a_sclk_high: assert property (p_sclk_high) else $error("sclk high phase wrong length");
  a_frame_len: assert property (p_frame_len) else $error("frame clock count illegal");
  a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
  a_lead: assert property (p_lead) else $error("sclk rose too soon after select");
  a_miso_idle: assert property (p_miso_idle) else $error("miso not low when idle");
endmodule

// ---- sensor_spi_programming_port_tb.sv ----
// Self-checking bench joining host and sensor ends over the serial link
module sensor_spi_programming_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Link clock kept under its speed limit; also leaves room for the miso round trip
  localparam int HALF = ssp_pkg::SCLK_HALF_CYC;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] angleIn = 12'h00F;
  logic systemStable = 1'b0;
  logic mchWrEn = 1'b0;
  logic [5:0] mchAddr = 6'h00;
  logic [7:0] mchData = 8'h00;
  logic mchAuxPulse = 1'b0;
  logic mchExit = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  ssp_pkg::ssp_owner_t pinOwner;
  logic mchSession;
  logic [20:0] turnsDelta;
  int failures = 0;
  int checksDone = 0;
  logic [15:0] got;
  logic [31:0] rx;

`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end

  ssp_if link ();
  always #2 clk = ~clk;

  ssp_device u_ssp_device (.clk(clk), .rstn(rstn), .ce(ce), .link(link.dev),
    .angleIn(angleIn), .systemStable(systemStable), .mchWrEn(mchWrEn), .mchAddr(mchAddr),
    .mchData(mchData), .mchAuxPulse(mchAuxPulse), .mchExit(mchExit), .pinOwner(pinOwner),
    .mchSession(mchSession), .turnsDelta(turnsDelta));
  ssp_host #(.HALF_CYC(HALF)) u_ssp_host (.clk(clk), .rstn(rstn), .ce(ce),
    .link(link.host), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  ssp_link_asserts #(.HALF_CYC(HALF)) u_ssp_link_asserts (.clk(clk), .rstn(rstn),
    .sclk(link.sclk), .csN(link.csN), .mosi(link.mosi), .miso(link.miso));

  function automatic logic [3:0] crc(input logic [15:0] d);
    logic [3:0] c;
    logic x;
    c = 4'hF;
    for (int i = 15; i >= 0; i--) begin
      x = d[i] ^ c[3];
      c = {c[2:1], c[0] ^ x, x};
    end
    return c;
  endfunction

  task hwr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task hrd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  // One whole frame; rx keeps what came back on miso
  task xfer(input logic [15:0] w, input logic [1:0] len);
    logic [31:0] s;
    s = 32'h1;
    hwr(ssp_pkg::H_FRAME, {14'h0, len, w});
    for (int n = 0; n < 400 && s[0]; n++) hrd(ssp_pkg::H_STAT, s);
    `CHK(s[0], 1'b0)
    hrd(ssp_pkg::H_RX, rx);
  endtask

  task rsel(input logic [5:0] a);
    xfer({2'b00, a, 8'h00}, 2'd0);
    got = rx[15:0];
  endtask

  task wr(input logic [5:0] a, input logic [7:0] d);
    xfer({2'b01, a, d}, 2'd0);
  endtask

  task mwr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    mchAddr <= a;
    mchData <= d;
    mchWrEn <= 1'b1;
    @(posedge clk);
    mchWrEn <= 1'b0;
  endtask

  task wrap_up;
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #300000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    systemStable <= 1'b1;
    #1 `CHK(pinOwner, ssp_pkg::OWN_MCH)
    wr(6'h04, 8'h00);
    wr(6'h05, 8'h01);
    wr(6'h06, 8'hD0);
    wr(6'h07, 8'h0F);
    rsel(6'h06);
    `CHK(got, 16'h000F)
    rsel(6'h05);
    `CHK(got, 16'hD00F)
    rsel(6'h20);
    `CHK(got, 16'h0001)
    xfer({2'b00, 6'h06, 8'h00}, 2'd2);
    `CHK(rx[15:0], 16'h000F)
    `CHK(rx[19:16], crc(16'h000F))
    `CHK(rx[20], 1'b1)
    // Accumulator must ignore a direct write
    wr(6'h2A, 8'h55);
    rsel(6'h2A);
    rsel(6'h22);
    `CHK(got, 16'h0000)
    rsel(6'h20);
    `CHK(got, 16'h0001)
    wr(6'h1E, 8'h03);
    wr(6'h1F, 8'h46);
    `CHK(turnsDelta, 21'h01D00F)
    rsel(6'h2A);
    rsel(6'h28);
    `CHK(got, 16'hD00F)
    rsel(6'h20);
    `CHK(got, 16'h0001)
    wr(6'h1E, 8'h01);
    wr(6'h1F, 8'h46);
    `CHK(turnsDelta, 21'h000000)
    wr(6'h1B, 8'h40);
    @(posedge clk);
    angleIn <= 12'h00A;
    wr(6'h1E, 8'h03);
    wr(6'h1F, 8'h46);
    `CHK(turnsDelta, 21'h01D00A)
    wr(6'h1B, 8'h00);
    // Illegal 17-bit write is dropped and flagged
    xfer({2'b01, 6'h07, 8'hAA}, 2'd1);
    rsel(6'h24);
    rsel(6'h06);
    `CHK(got, 16'h0001)
    rsel(6'h24);
    `CHK(got, 16'hD00F)
    rsel(6'h20);
    `CHK(got, 16'h0000)
    // Checked 20-bit write with a good code must land
    wr(6'h1B, 8'h01);
    xfer({2'b01, 6'h07, 8'h5A}, 2'd2);
    rsel(6'h06);
    rsel(6'h20);
    `CHK(got, 16'hD05A)
    wr(6'h1B, 8'h02);
    xfer({2'b00, 6'h24, 8'h00}, 2'd0);
    xfer({2'b00, 6'h24, 8'h00}, 2'd1);
    xfer({2'b00, 6'h24, 8'h00}, 2'd1);
    `CHK(rx[15:0], 16'h0001)
    xfer({2'b01, 6'h1B, 8'h00}, 2'd1);
    mwr(6'h05, 8'h33);
    rsel(6'h04);
    rsel(6'h20);
    `CHK(got, 16'h0033)
    wr(6'h1B, 8'h04);
    `CHK(pinOwner, ssp_pkg::OWN_PWM)
    @(posedge clk);
    mchAuxPulse <= 1'b1;
    @(posedge clk);
    mchAuxPulse <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(pinOwner, ssp_pkg::OWN_MCH)
    `CHK(mchSession, 1'b1)
    wr(6'h1D, 8'h01);
    `CHK(pinOwner, ssp_pkg::OWN_SPI)
    `CHK(mchSession, 1'b0)
    mwr(6'h1D, 8'h00);
    repeat (2) @(posedge clk);
    #1 `CHK(pinOwner, ssp_pkg::OWN_SPI)
    wr(6'h1D, 8'h00);
    wr(6'h1B, 8'h10);
    `CHK(pinOwner, ssp_pkg::OWN_SENT)
    @(posedge clk);
    mchAuxPulse <= 1'b1;
    @(posedge clk);
    mchAuxPulse <= 1'b0;
    #1 `CHK(mchSession, 1'b1)
    @(posedge clk);
    mchExit <= 1'b1;
    @(posedge clk);
    mchExit <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(mchSession, 1'b0)
    `CHK(pinOwner, ssp_pkg::OWN_SENT)
    wr(6'h1B, 8'h08);
    `CHK(pinOwner, ssp_pkg::OWN_SPI)
    mwr(6'h05, 8'h77);
    rsel(6'h04);
    rsel(6'h20);
    `CHK(got, 16'h0033)
    // Locked settings byte refuses further writes
    wr(6'h1B, 8'h80);
    wr(6'h1B, 8'h02);
    rsel(6'h1A);
    rsel(6'h20);
    `CHK(got, 16'h0080)
    // Clock enable low freezes the accumulator and its angle history
    @(posedge clk);
    ce <= 1'b0;
    angleIn <= 12'h00D;
    repeat (3) @(posedge clk);
    #1 `CHK(turnsDelta, 21'h01D00A)
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(turnsDelta, 21'h01D00D)
    wrap_up();
  end
endmodule
